// File: design/wakeup_seq_regs.vh
// Register map and timing constants for the stack wakeup sequencer.
// Assumes inclusion by bare name from design files under design/.
`ifndef WAKEUP_SEQ_REGS_VH
`define WAKEUP_SEQ_REGS_VH

// Register byte offsets on AXI4-Lite
`define OFF_CTRL 12'h000
`define OFF_CONFIG 12'h004
`define OFF_STATUS 12'h008
`define OFF_FAULT 12'h00c
`define OFF_ADDR 12'h010
`define OFF_TONE_LEN 12'h014
`define OFF_NVM_DATA 12'h018

// Control register fields
`define CTRL_SOFT_RESET 0
`define CTRL_PWRDN 1
`define CTRL_SAMPLE_ALL 2
// Config register fields
`define CFG_ADDR_SEL 0
`define CFG_REG_DISABLE 1
// Status register fields
`define ST_INIT 0
`define ST_STATE_LSB 1
`define ST_UART_EN 8
`define ST_STACK_EN 9
`define ST_REG_ON 10
`define ST_TONE_BUSY 11
`define ST_AFAULT_EN 12
`define ST_VALID 13
// Fault register fields
`define FLT_RESET 0
`define FLT_UV 1
`define FLT_OV 2
`define FLT_AUX 3
`define FLT_REF 4
`define FLT_REF_GND 5
`define FLT_MASKED 6

// Reset values
`define CONFIG_RST 2'h0
`define TONE_LEN_RST 16'h0100
`define NVM_DATA_RST 32'h0000_0000
`define FAULT_RST 6'h01

// Timing and AXI4-Lite response codes
`define CLK_MHZ 125
`define NVM_WAIT_NS 10000
`define TONE_HALF_CYC 8'h3f
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: design/wake_tone_gen.v
// Wake tone pulse train generator for the high-side link.
// Assumes one clock domain; start is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_seq_regs.vh"
module wake_tone_gen (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire [15:0] length,
  output reg tone_p,
  output reg tone_n,
  output reg tone_oe,
  output reg busy,
  output reg done
);
  reg [15:0] left_r;
  reg [7:0] half_r;

  // Restart on a new start so a re-wake always sends a full tone
  always @(posedge aclk) begin
    if (!aresetn) begin
      left_r <= 16'h0000;
      half_r <= 8'h00;
      tone_p <= 1'b0;
      tone_n <= 1'b0;
      tone_oe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      left_r <= (length == 16'h0000) ? 16'h0001 : length;
      half_r <= `TONE_HALF_CYC;
      tone_p <= 1'b1;
      tone_n <= 1'b0;
      tone_oe <= 1'b1;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      if (half_r != 8'h00) begin
        half_r <= half_r - 8'h01;
      end else if (left_r == 16'h0001) begin
        tone_oe <= 1'b0;
        tone_p <= 1'b0;
        tone_n <= 1'b0;
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        half_r <= `TONE_HALF_CYC;
        left_r <= left_r - 16'h0001;
        tone_p <= ~tone_p;
        tone_n <= tone_p;
      end
    end
  end
endmodule // wake_tone_gen
`default_nettype wire

// File: design/stack_wakeup_init_sequencer.v
// Wakeup and power-on initialization sequencer for one stacked monitor device.
// Assumes aclk runs once supplies pass thresholds; pins are asynchronous and synchronised here.
// Overview of operation
// - Leave shutdown for idle when wake pin is high or low-side tone arrives.
// - Going from shutdown to idle sends a brief wake tone on high-side link.
// - Power-down with wake pin high wakes the device again at once.
// - A device woken by low-side tone relays a tone up the high-side link.
// - In shutdown the low-side link stays in receive, never transmitting.
// - Wakeup fully resets the sequencer, reloads NVM registers, keeps tone length and NVM data.
// - After reset sampled fault bits read zero until a sample-all command runs.
// - Same init sequence for power-on, soft reset and received wake tone.
// - Sequencer starts with the clock and begins the high-side tone at once.
// - Wait about 10 us for NVM ready, then load system registers.
// - With address select 0, sample five pins as communication address.
// - Sample only digital-die temperature; no faults from unsampled channels.
// - Clear masked startup faults, then begin host serial port monitoring.
// - In parallel wait for no supply fault or host init write, then enable.
// - Wait for outgoing tone to finish before stack link monitoring.
// - After host clears reset fault, regulator off when regulator-off bit is 1.
// - Early host traffic needs resync; stack link resyncs each frame.
// - Return to shutdown unless I/O supply is good within its delay.
// - Soft reset reruns full wakeup sequence without powering down.
// - Wake tone while awake causes reset and regenerates tone upward.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_seq_regs.vh"
module stack_wakeup_init_sequencer #(
  parameter IO_SD_CYC = 32'd125000
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire wake_pin,
  input wire low_side_link_tone,
  output wire low_side_link_oe,
  output wire high_side_link_p,
  output wire high_side_link_n,
  output wire high_side_link_oe,
  input wire io_supply_ok,
  input wire negative_supply_fault,
  input wire [4:0] gpio_addr,
  input wire temp_done,
  output reg temp_sample,
  output reg host_port_en,
  output reg stack_link_en,
  output reg regulator_on,
  output reg analog_fault_en,
  output reg powered
);
  localparam [31:0] NVM_WAIT_CYC = (`NVM_WAIT_NS * `CLK_MHZ + 999) / 1000;

  localparam [7:0] S_SHUT = 8'h01;
  localparam [7:0] S_START = 8'h02;
  localparam [7:0] S_NVM = 8'h04;
  localparam [7:0] S_LOAD = 8'h08;
  localparam [7:0] S_TEMP = 8'h10;
  localparam [7:0] S_CLEAR = 8'h20;
  localparam [7:0] S_TONE = 8'h40;
  localparam [7:0] S_RUN = 8'h80;

  // Two-flop synchronisers for pins
  reg [4:0] sa_r;
  reg [4:0] sb_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sa_r <= 5'h00;
      sb_r <= 5'h00;
    end else begin
      sa_r <= {negative_supply_fault, io_supply_ok, low_side_link_tone, wake_pin, 1'b0};
      sb_r <= sa_r;
    end
  end
  wire wake_s = sb_r[1];
  wire tone_s = sb_r[2];
  wire io_ok_s = sb_r[3];
  wire vm_flt_s = sb_r[4];
  reg [4:0] gpio_a_r;
  reg [4:0] gpio_s_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      gpio_a_r <= 5'h00;
      gpio_s_r <= 5'h00;
    end else begin
      gpio_a_r <= gpio_addr;
      gpio_s_r <= gpio_a_r;
    end
  end
  reg tone_prev_r;

  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [31:0] cnt_r;
  reg [31:0] io_cnt_r;
  reg init_r;
  reg valid_r;
  reg [5:0] fault_r;
  reg [1:0] config_r;
  reg [4:0] addr_r;
  reg [15:0] tone_len_r;
  reg [31:0] nvm_r;
  reg tone_start;
  wire tone_busy;
  wire tone_done;
  reg tone_done_r;

  // AXI4-Lite write path: address and data accepted in either order
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  wire wr_go = aw_held_r && w_held_r;
  wire wr_ctrl = wr_go && awaddr_r == `OFF_CTRL && wstrb_r[0];
  wire wr_status = wr_go && awaddr_r == `OFF_STATUS && wstrb_r[0];
  wire wr_fault = wr_go && awaddr_r == `OFF_FAULT && wstrb_r[0];
  wire wr_known = awaddr_r == `OFF_CTRL || awaddr_r == `OFF_CONFIG || awaddr_r == `OFF_STATUS ||
                  awaddr_r == `OFF_FAULT || awaddr_r == `OFF_TONE_LEN || awaddr_r == `OFF_NVM_DATA;
  wire soft_rst = wr_ctrl && wdata_r[`CTRL_SOFT_RESET];
  wire pwrdn = wr_ctrl && wdata_r[`CTRL_PWRDN];
  wire sample_all = wr_ctrl && wdata_r[`CTRL_SAMPLE_ALL];
  // Edge, not level: one long tone restarts the sequencer only once
  wire tone_rise = tone_s && !tone_prev_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers: tone length and NVM data kept across the sequencer's own resets, config reloaded
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= `CONFIG_RST;
      tone_len_r <= `TONE_LEN_RST;
      nvm_r <= `NVM_DATA_RST;
    end else begin
      if (wr_go && wstrb_r[0] && awaddr_r == `OFF_TONE_LEN) tone_len_r <= wdata_r[15:0];
      if (wr_go && wstrb_r[0] && awaddr_r == `OFF_NVM_DATA) nvm_r <= wdata_r;
      // A host write landing on the reload edge must not skip the reload
      if (state_r == S_LOAD) begin
        config_r <= nvm_r[1:0]; // Stored configuration reloaded at wakeup
      end else if (wr_go && wstrb_r[0] && awaddr_r == `OFF_CONFIG) begin
        config_r <= wdata_r[1:0];
      end
    end
  end

  // Sequencer state machine
  always @* begin
    state_nxt = state_r;
    tone_start = 1'b0;
    case (state_r)
      S_SHUT: begin
        // Low-side link only listens here
        if (wake_s || tone_rise) state_nxt = S_START;
      end
      S_START: begin
        tone_start = 1'b1; // Tone on every wake, relayed upward
        state_nxt = S_NVM;
      end
      S_NVM: if (cnt_r >= NVM_WAIT_CYC - 32'd1) state_nxt = S_LOAD;
      S_LOAD: state_nxt = S_TEMP;
      S_TEMP: if (temp_done) state_nxt = S_CLEAR;
      S_CLEAR: state_nxt = S_TONE;
      // Done flag covers a tone that ended before this state was reached
      S_TONE: if (tone_done_r || !tone_busy) state_nxt = S_RUN;
      S_RUN: state_nxt = S_RUN;
      default: state_nxt = S_SHUT;
    endcase
    // Same restart path for soft reset and tone while awake
    if (state_r != S_SHUT && (soft_rst || tone_rise)) begin
      state_nxt = S_START;
      tone_start = 1'b0;
    end
    // Power-down only holds if wake pin is low; otherwise rewake
    if (state_r != S_SHUT && pwrdn) state_nxt = wake_s ? S_START : S_SHUT;
    // I/O supply must come good within its delay
    if (state_r != S_SHUT && !io_ok_s && io_cnt_r >= IO_SD_CYC) state_nxt = S_SHUT;
  end

  // Host abort written early is kept until the fault step may act on it
  reg init_abort_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      init_abort_r <= 1'b0;
    end else if (state_nxt == S_START || state_nxt == S_SHUT) begin
      init_abort_r <= 1'b0;
    end else if (wr_status && wdata_r[`ST_INIT]) begin
      init_abort_r <= 1'b1;
    end
  end

  // Outputs and state follow the FSM; sequencer restart clears valid, sampled faults and enables, sets init and reset fault, keeps addr_r
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_START; // Clock running means supplies passed, so start at once
      cnt_r <= 32'h0000_0000;
      io_cnt_r <= 32'h0000_0000;
      tone_prev_r <= 1'b0;
      tone_done_r <= 1'b0;
      init_r <= 1'b1;
      valid_r <= 1'b0;
      // Power-on counts as a restart, so the reset-occurred flag starts set
      fault_r <= `FAULT_RST;
      addr_r <= 5'h00;
      temp_sample <= 1'b0;
      host_port_en <= 1'b0;
      stack_link_en <= 1'b0;
      regulator_on <= 1'b1;
      analog_fault_en <= 1'b0;
      powered <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tone_prev_r <= tone_s;
      cnt_r <= (state_nxt == state_r) ? cnt_r + 32'd1 : 32'h0000_0000;
      // Supply-loss timer idles in shutdown so the next wake starts it from zero
      io_cnt_r <= (state_r == S_SHUT || io_ok_s) ? 32'h0000_0000 : io_cnt_r + 32'd1;
      temp_sample <= (state_r == S_LOAD);
      if (tone_start) tone_done_r <= 1'b0;
      else if (tone_done) tone_done_r <= 1'b1;
      if (state_nxt == S_START || state_nxt == S_SHUT) begin
        init_r <= 1'b1;
        valid_r <= 1'b0; // Sampled faults zero and invalid after reset
        fault_r <= {5'h00, state_nxt == S_START};
        host_port_en <= 1'b0;
        stack_link_en <= 1'b0;
        analog_fault_en <= 1'b0;
        regulator_on <= (state_nxt == S_START);
        powered <= (state_nxt == S_START);
      end else begin
        // Select is reloaded on this same edge, so read its stored copy
        if (state_r == S_LOAD && !nvm_r[`CFG_ADDR_SEL]) addr_r <= gpio_s_r;
        if (state_r == S_CLEAR) begin
          fault_r[5:1] <= 5'h00;
          host_port_en <= 1'b1;
        end
        if (state_r == S_TONE && state_nxt == S_RUN) stack_link_en <= 1'b1;
        // Parallel analog fault init once past the NVM wait, from register load on
        if (init_r && state_r != S_NVM && state_r != S_START &&
            (!vm_flt_s || init_abort_r ||
             (wr_status && wdata_r[`ST_INIT]))) begin
          analog_fault_en <= 1'b1;
          init_r <= 1'b0;
        end
        // Host clears reset fault by writing 1; set has no source while awake
        if (wr_fault && wdata_r[`FLT_RESET]) fault_r[`FLT_RESET] <= 1'b0;
        if (sample_all) valid_r <= 1'b1; // Only a sample command validates
        // Regulator turns off once reset fault cleared, if configured
        if (!fault_r[`FLT_RESET] && config_r[`CFG_REG_DISABLE] && state_r == S_RUN) regulator_on <= 1'b0;
      end
    end
  end

  wake_tone_gen u_tone (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tone_start),
    .length(tone_len_r),
    .tone_p(high_side_link_p),
    .tone_n(high_side_link_n),
    .tone_oe(high_side_link_oe),
    .busy(tone_busy),
    .done(tone_done)
  );

  // Low side never transmits from this block; frames own it later
  assign low_side_link_oe = 1'b0;

  // Status bits sit at the positions named in the register header
  wire [31:0] status_word = {18'h0, valid_r, analog_fault_en, tone_busy, regulator_on,
                             stack_link_en, host_port_en, state_r[6:0], init_r};

  // AXI4-Lite read path; reads have no side effect on faults
  // One read in flight keeps rdata steady until rready
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case ({s_axi_araddr[11:2], 2'b00})
        `OFF_CTRL: s_axi_rdata <= 32'h0000_0000;
        `OFF_CONFIG: s_axi_rdata <= {30'h0, config_r};
        `OFF_STATUS: s_axi_rdata <= status_word;
        `OFF_FAULT: s_axi_rdata <= {26'h0, fault_r};
        `OFF_ADDR: s_axi_rdata <= {27'h0, addr_r};
        `OFF_TONE_LEN: s_axi_rdata <= {16'h0, tone_len_r};
        `OFF_NVM_DATA: s_axi_rdata <= nvm_r;
        default: s_axi_rresp <= `RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // stack_wakeup_init_sequencer
`default_nettype wire

// File: tb/wakeup_seq_props.sv
// Port checker for the stack wakeup sequencer.
// Assumes binding to the top design module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wakeup_seq_props #(
  parameter IO_SD_CYC = 32'd125000
) (
  input wire aclk,
  input wire aresetn,
  input wire wake_pin,
  input wire low_side_link_tone,
  input wire low_side_link_oe,
  input wire high_side_link_oe,
  input wire high_side_link_p,
  input wire high_side_link_n,
  input wire io_supply_ok,
  input wire temp_sample,
  input wire host_port_en,
  input wire stack_link_en,
  input wire regulator_on,
  input wire powered
);
  localparam int NVM_CYC = 1250;
  logic [31:0] io_cnt_r;
  logic [11:0] wait_cnt_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counters saturate or clear so long runs cannot wrap into a false pass
  always @(posedge aclk) begin
    if (!aresetn || !powered || io_supply_ok) io_cnt_r <= 32'h0;
    else io_cnt_r <= io_cnt_r + 32'h1;
    if (!aresetn || host_port_en) wait_cnt_r <= 12'h0;
    else if (wait_cnt_r != 12'hfff) wait_cnt_r <= wait_cnt_r + 12'h1;
  end
  sequence wake_up_s;
    ##[1:8] powered ##[0:6] high_side_link_oe;
  endsequence
  a_lsl_rx_only: assert property (low_side_link_oe == 1'b0)
    else $error("low side link driven");
  a_tone_at_start: assert property ($rose(aresetn) |-> ##[0:6] high_side_link_oe)
    else $error("no tone after start");
  a_wake_pin_up: assert property (!powered && wake_pin |-> wake_up_s)
    else $error("wake pin did not wake");
  a_tone_relay: assert property (!powered && $rose(low_side_link_tone) |-> wake_up_s)
    else $error("tone did not wake and relay");
  a_tone_restart: assert property (host_port_en && $rose(low_side_link_tone) |-> ##[1:8] !host_port_en)
    else $error("tone while awake did not restart");
  a_nvm_wait: assert property ($rose(host_port_en) |-> wait_cnt_r >= NVM_CYC)
    else $error("memory wait too short");
  a_temp_first: assert property (temp_sample |-> !host_port_en)
    else $error("temperature sampled after port enable");
  a_stack_after_tone: assert property ($rose(stack_link_en) |-> host_port_en && !high_side_link_oe)
    else $error("stack link enabled early");
  a_pd_needs_low: assert property ($fell(powered) && io_supply_ok |-> !$past(wake_pin, 4))
    else $error("shut down with wake pin high");
  a_io_sd_limit: assert property (io_cnt_r <= IO_SD_CYC + 6)
    else $error("stayed awake without io supply");
  a_reg_off_late: assert property ($fell(regulator_on) && powered |-> host_port_en)
    else $error("regulator off before init");
  a_tone_diff_pair: assert property (high_side_link_oe |-> high_side_link_p != high_side_link_n)
    else $error("tone pair not complementary");
endmodule // wakeup_seq_props
bind stack_wakeup_init_sequencer wakeup_seq_props #(.IO_SD_CYC(IO_SD_CYC)) wakeup_seq_props_inst (
  .aclk, .aresetn, .wake_pin, .low_side_link_tone, .low_side_link_oe, .high_side_link_oe,
  .high_side_link_p, .high_side_link_n,
  .io_supply_ok, .temp_sample, .host_port_en, .stack_link_en, .regulator_on, .powered);
`default_nettype wire

// File: tb/far_side_model.sv
// Far side: device below sending a tone, and the temperature channel.
// Assumes one clock; tone_req is a level from the bench.
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter int TEMP_DLY = 3
) (
  input wire logic aclk,
  input wire logic temp_sample,
  input wire logic tone_req,
  output logic temp_done,
  output logic low_side_link_tone
);
  int cnt = 0;
  int tcnt = 0;
  logic req_q = 1'b0;
  initial temp_done = 1'b0;
  initial low_side_link_tone = 1'b0;
  // Slow answer on purpose so the sequencer really waits for it
  always @(posedge aclk) begin
    temp_done <= 1'b0;
    if (temp_sample) cnt <= TEMP_DLY;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      temp_done <= 1'b1;
    end
    req_q <= tone_req;
    if (tone_req && !req_q) tcnt <= 6;
    else if (tcnt > 0) tcnt <= tcnt - 1;
    low_side_link_tone <= (tcnt > 0);
  end
endmodule // far_side_model
`default_nettype wire

// File: tb/stack_wakeup_init_sequencer_tb.sv
// Self-checking bench for the stack wakeup sequencer.
// Assumes the design and its register header under design/.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_seq_regs.vh"
module stack_wakeup_init_sequencer_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake_pin;
  logic low_side_link_tone, low_side_link_oe, high_side_link_oe, io_supply_ok, negative_supply_fault;
  logic temp_done, temp_sample, host_port_en, stack_link_en, regulator_on, analog_fault_en, powered, tone_req;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] gpio_addr;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  stack_wakeup_init_sequencer #(.IO_SD_CYC(32'd20)) stack_wakeup_init_sequencer_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wake_pin, .low_side_link_tone, .low_side_link_oe, .high_side_link_p(), .high_side_link_n(),
    .high_side_link_oe, .io_supply_ok, .negative_supply_fault, .gpio_addr, .temp_done, .temp_sample,
    .host_port_en, .stack_link_en, .regulator_on, .analog_fault_en, .powered);
  far_side_model #(.TEMP_DLY(40)) far_side_model_inst (
    .aclk, .temp_sample, .tone_req, .temp_done, .low_side_link_tone);
  always #4 aclk = ~aclk;
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Two init passes with full tones are about 35k cycles; the rest is short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic wait_port(input logic lvl);
    while (host_port_en !== lvl) @(posedge aclk);
  endtask
  initial begin
    aclk = 0;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tone_req} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    wake_pin = 0;
    io_supply_ok = 1;
    negative_supply_fault = 1;
    gpio_addr = 5'h15;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`OFF_STATUS);
    chk(rd[`ST_INIT], 1'b1);
    chk(rd[`ST_VALID], 1'b0);
    rdr(`OFF_FAULT);
    chk(rd[5:0], 6'h01);
    wait_port(1'b1);
    chk(stack_link_en, 1'b0);
    chk(analog_fault_en, 1'b0);
    rdr(`OFF_ADDR);
    chk(rd[4:0], 5'h15);
    rdr(`OFF_CONFIG);
    chk(rd[1:0], `CONFIG_RST);
    rdr(`OFF_TONE_LEN);
    chk(rd[15:0], `TONE_LEN_RST);
    wr(`OFF_CTRL, 32'h4);
    wr(`OFF_STATUS, 32'h1);
    rdr(`OFF_STATUS);
    chk(rd[`ST_INIT], 1'b0);
    chk(rd[`ST_VALID], 1'b1);
    chk(analog_fault_en, 1'b1);
    while (stack_link_en !== 1'b1) @(posedge aclk);
    chk(high_side_link_oe, 1'b0);
    wr(12'h01c, 32'h0);
    chk(resp, `RESP_SLVERR);
    rdr(12'h01c);
    chk({rd[29:0], resp}, {30'h0, `RESP_SLVERR});
    wr(`OFF_NVM_DATA, 32'h2);
    wr(`OFF_FAULT, 32'h1);
    chk(regulator_on, 1'b1);
    wr(`OFF_CTRL, 32'h1);
    wait_port(1'b0);
    chk(powered, 1'b1);
    wait_port(1'b1);
    rdr(`OFF_CONFIG);
    chk(rd[1:0], 2'h2);
    rdr(`OFF_FAULT);
    chk(rd[5:0], 6'h01);
    negative_supply_fault <= 1'b0;
    repeat (4) @(posedge aclk);
    rdr(`OFF_STATUS);
    chk({rd[`ST_VALID], rd[`ST_INIT], analog_fault_en}, 3'h1);
    chk(regulator_on, 1'b1);
    wr(`OFF_FAULT, 32'h1);
    while (stack_link_en !== 1'b1) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(regulator_on, 1'b0);
    wake_pin <= 1'b1;
    wr(`OFF_CTRL, 32'h2);
    repeat (10) @(posedge aclk);
    chk(powered, 1'b1);
    wake_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    wr(`OFF_CTRL, 32'h2);
    repeat (6) @(posedge aclk);
    chk(powered, 1'b0);
    chk(low_side_link_oe, 1'b0);
    tone_req <= 1'b1;
    repeat (12) @(posedge aclk);
    chk({powered, high_side_link_oe}, 2'h3);
    wait_port(1'b1);
    tone_req <= 1'b0;
    @(posedge aclk);
    tone_req <= 1'b1;
    repeat (12) @(posedge aclk);
    chk({host_port_en, high_side_link_oe}, 2'h1);
    wait_port(1'b1);
    io_supply_ok <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(powered, 1'b0);
    io_supply_ok <= 1'b1;
    wake_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(powered, 1'b1);
    wake_pin <= 1'b0;
    end_of_test();
  end
endmodule // stack_wakeup_init_sequencer_tb
`default_nettype wire
